//--- rtl/ddrc_pkg.sv
// shared constants and types for the registered command decode block
package ddrc_pkg;
  localparam int ADDR_W      = 13;
  localparam int BANK_W      = 2;
  localparam int COL_W       = 13;
  localparam int DATA_W      = 16;
  localparam int LOCK_CYCLES = 200;
  localparam int LAT_W       = 3;

  localparam logic [2:0] BL_CODE_2  = 3'h1;
  localparam logic [2:0] BL_CODE_4  = 3'h2;
  localparam logic [2:0] BL_CODE_8  = 3'h3;
  localparam logic [2:0] CL_CODE_2  = 3'h2;
  localparam logic [2:0] CL_CODE_3  = 3'h3;
  localparam logic [2:0] CL_CODE_25 = 3'h6;

  localparam int MR_BL_LSB  = 0;
  localparam int MR_BT_BIT  = 3;
  localparam int MR_CL_LSB  = 4;
  localparam int MR_OP_LSB  = 7;
  localparam int MR_OP_W    = 6;
  localparam int AP_BIT     = 10;
  localparam int EMR_LOCK_DIS_BIT = 0;
  localparam int EMR_DRIVE_BIT    = 1;

  localparam logic [5:0] OP_NORMAL     = 6'h00;
  localparam logic [5:0] OP_LOCK_RESET = 6'h02;
  localparam logic [1:0] BANK_MODE     = 2'h0;
  localparam logic [1:0] BANK_EXT      = 2'h1;

  localparam logic [12:0] MR_RESET  = 13'h0021;
  localparam logic [12:0] EMR_RESET = 13'h0000;

  typedef enum logic [3:0] {
    DDRC_NOP, DDRC_DESEL, DDRC_ACT, DDRC_RD, DDRC_WR, DDRC_BST,
    DDRC_PRE, DDRC_AREF, DDRC_SREF, DDRC_MRS, DDRC_ILL
  } ddrc_cmd_e;

  // half-clock latency counted in half steps: 2 -> 4, 2.5 -> 5, 3 -> 6
  localparam logic [3:0] HALF_2  = 4'h4;
  localparam logic [3:0] HALF_25 = 4'h5;
  localparam logic [3:0] HALF_3  = 4'h6;
endpackage : ddrc_pkg

//--- rtl/ddrc_burst_order.sv
// burst column order generator
module ddrc_burst_order
  import ddrc_pkg::*;
(
  input  wire logic [COL_W-1:0] start_col,
  input  wire logic [2:0]       beat,
  input  wire logic [2:0]       bl_code,
  input  wire logic             interleave,
  output logic      [COL_W-1:0] col
);
  logic [2:0] mask;
  logic [2:0] low;
  always_comb
  begin
    case (bl_code)
      BL_CODE_2: mask = 3'h1;
      BL_CODE_4: mask = 3'h3;
      default:   mask = 3'h7;
    endcase
    if (interleave)
      low = start_col[2:0] ^ beat;
    else
      low = 3'(start_col[2:0] + beat);
    // wrap inside the aligned block, upper bits untouched
    col = {start_col[COL_W-1:3], (start_col[2:0] & ~mask) | (low & mask)};
  end
endmodule : ddrc_burst_order

//--- rtl/ddrc_skid2.sv
// two-entry buffer for read data
module ddrc_skid2
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            cnt;
  } ddrc_skid_s;
  ddrc_skid_s st, next_st;
  logic push, pop;
  always_comb
  begin
    next_st = st;
    pop  = out_valid & out_ready;
    push = in_valid & in_ready;
    if (pop)
    begin
      next_st.mem[0] = st.mem[1];
      next_st.cnt    = 2'(st.cnt - 2'h1);
    end
    if (push)
    begin
      next_st.mem[next_st.cnt[0]] = in_data;
      next_st.cnt = 2'(next_st.cnt + 2'h1);
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end
  assign in_ready  = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data  = st.mem[0];
endmodule : ddrc_skid2

//--- rtl/ddrc_top.sv
// registered command decode, mode registers, read timing and burst order
module ddrc_top
  import ddrc_pkg::*;
#(
  parameter int COL_TOP = 12
)
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              cke,
  input  wire logic              cs_b,
  input  wire logic              ras_b,
  input  wire logic              cas_b,
  input  wire logic              we_b,
  input  wire logic              bank_select_low,
  input  wire logic              bank_select_high,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] core_rd_data,
  input  wire logic              rd_ready,
  output logic                   rd_valid,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_stall,
  output logic      [3:0]        cmd_code,
  output logic      [BANK_W-1:0] cmd_bank,
  output logic                   auto_precharge,
  output logic      [3:0]        precharge_banks,
  output logic      [COL_W-1:0]  burst_col,
  output logic                   burst_active,
  output logic                   burst_is_write,
  output logic                   first_data,
  output logic      [2:0]        read_latency_setting,
  output logic      [1:0]        burst_len_code,
  output logic                   burst_interleave,
  output logic                   lock_enabled,
  output logic                   lock_reset_pulse,
  output logic                   lock_ready,
  output logic                   drive_reduced,
  output logic                   self_refresh,
  output logic                   refresh_pulse
);
  typedef struct packed {
    logic [1:0]        cke_s;
    logic              cke_q;
    logic              cs_q, ras_q, cas_q, we_q;
    logic [BANK_W-1:0] ba_q;
    logic [ADDR_W-1:0] a_q;
    logic [12:0]       mr;
    logic [12:0]       emr;
    logic              self_ref;
    logic              ref_p;
    logic              lrst_p;
    logic [7:0]        lock_cnt;
    logic              lock_rdy;
    logic              lock_hold;
    ddrc_cmd_e         cmd;
    logic [BANK_W-1:0] bank;
    logic              ap;
    logic [3:0]        pre_banks;
    logic              bst;
    logic              bwr;
    logic [COL_W-1:0]  start;
    logic [2:0]        beat;
    logic [2:0]        beats_left;
    logic [7:0]        rd_pipe;
    logic [3:0]        lat_half;
    logic              first;
    logic              emit;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] dout;
    logic              dvalid;
    logic              stall;
  } ddrc_top_s;

  ddrc_top_s st, next_st;
  logic [COL_W-1:0] order_col;
  logic             buf_in_ready;
  logic             buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;

  function automatic ddrc_cmd_e decode(input logic c, input logic ce,
                                       input logic r, input logic ca,
                                       input logic w);
    if (c)
      return DDRC_DESEL;
    case ({r, ca, w})
      3'h7: return DDRC_NOP;
      3'h3: return DDRC_ACT;
      3'h5: return DDRC_RD;
      3'h4: return DDRC_WR;
      3'h6: return DDRC_BST;
      3'h2: return DDRC_PRE;
      3'h1: return ce ? DDRC_AREF : DDRC_SREF;
      3'h0: return DDRC_MRS;
      default: return DDRC_ILL;
    endcase
  endfunction : decode

  function automatic logic [2:0] beats_of(input logic [2:0] code);
    case (code)
      BL_CODE_2: return 3'h1;
      BL_CODE_4: return 3'h3;
      default:   return 3'h7;
    endcase
  endfunction : beats_of

  function automatic logic [3:0] half_of(input logic [2:0] code);
    case (code)
      CL_CODE_2:  return HALF_2;
      CL_CODE_25: return HALF_25;
      default:    return HALF_3;
    endcase
  endfunction : half_of

  ddrc_burst_order u_order (
    .start_col  (st.start),
    .beat       (st.beat),
    .bl_code    (st.mr[MR_BL_LSB +: 3]),
    .interleave (st.mr[MR_BT_BIT]),
    .col        (order_col)
  );

  ddrc_skid2 #(.WIDTH(DATA_W)) u_buf (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (st.emit),
    .in_ready  (buf_in_ready),
    .in_data   (core_rd_data),
    .out_valid (buf_out_valid),
    .out_ready (rd_ready),
    .out_data  (buf_out_data)
  );

  always_comb
  begin
    ddrc_cmd_e c;
    logic [COL_W-1:0] col_in;
    next_st = st;
    c = DDRC_NOP;
    col_in = '0;
    // pin inputs synchronised; clock enable via three flops
    next_st.cke_s = {st.cke_s[0], cke};
    next_st.cke_q = st.cke_s[1];
    // input register stage adds one clock
    next_st.cs_q  = cs_b;
    next_st.ras_q = ras_b;
    next_st.cas_q = cas_b;
    next_st.we_q  = we_b;
    next_st.ba_q  = {bank_select_high, bank_select_low};
    next_st.a_q   = addr;
    next_st.ref_p  = 1'b0;
    next_st.lrst_p = 1'b0;
    next_st.first  = 1'b0;
    next_st.emit   = 1'b0;
    next_st.rd_pipe[0] = 1'b0;
    next_st.dvalid = buf_out_valid;
    next_st.dout   = buf_out_data;
    next_st.stall  = ~buf_in_ready;
    next_st.cmd    = DDRC_NOP;
    // column bits: a0..a9, a11, a12 with a10 skipped
    col_in = {st.a_q[12], st.a_q[11], 1'b0, st.a_q[9:0]};
    col_in = col_in & COL_W'((1 << (COL_TOP + 1)) - 1);
    if (st.self_ref)
    begin
      // only clock enable matters while in self refresh
      if (st.cke_q)
      begin
        next_st.self_ref = 1'b0;
        next_st.emr[EMR_LOCK_DIS_BIT] = 1'b0;
      end
    end
    else if (st.cke_q || !st.cs_q)
    begin
      c = decode(st.cs_q, st.cke_q, st.ras_q, st.cas_q, st.we_q);
      next_st.cmd = c;
      case (c)
        DDRC_RD, DDRC_WR:
        begin
          next_st.bank = st.ba_q;
          next_st.ap   = st.a_q[AP_BIT];
          next_st.start = col_in;
          next_st.beat  = '0;
          next_st.beats_left = beats_of(st.mr[MR_BL_LSB +: 3]);
          next_st.bwr = (c == DDRC_WR);
          next_st.bst = 1'b1;
          if (c == DDRC_RD)
            next_st.rd_pipe[0] = 1'b1;
        end
        DDRC_BST:
          if (!st.bwr && !st.ap)
            next_st.bst = 1'b0;
        DDRC_PRE:
        begin
          next_st.bank = st.ba_q;
          if (st.a_q[AP_BIT])
            next_st.pre_banks = 4'hf;
          else
            next_st.pre_banks = 4'(1 << st.ba_q);
        end
        DDRC_AREF: next_st.ref_p = 1'b1;
        DDRC_SREF: next_st.self_ref = 1'b1;
        DDRC_MRS:
        begin
          if (st.ba_q == BANK_MODE)
          begin
            if (st.a_q[MR_OP_LSB +: MR_OP_W] == OP_NORMAL)
              next_st.mr = {OP_NORMAL, st.a_q[MR_OP_LSB-1:0]};
            else if (st.a_q[MR_OP_LSB +: MR_OP_W] == OP_LOCK_RESET)
            begin
              // bit 8 never stored: it clears itself
              next_st.mr = {OP_NORMAL, st.a_q[MR_OP_LSB-1:0]};
              next_st.lrst_p = 1'b1;
              next_st.lock_cnt = '0;
              next_st.lock_rdy = 1'b0;
              next_st.lock_hold = 1'b0;
            end
          end
          else if (st.ba_q == BANK_EXT)
            next_st.emr = st.a_q;
        end
        default: ;
      endcase
    end
    // lock ready after reset and enough clocks with cke high
    if (!st.lock_rdy && !st.lock_hold && st.cke_q &&
        !st.emr[EMR_LOCK_DIS_BIT])
    begin
      if (st.lock_cnt == 8'(LOCK_CYCLES - 1))
        next_st.lock_rdy = 1'b1;
      else
        next_st.lock_cnt = 8'(st.lock_cnt + 8'h1);
    end
    if (st.emr[EMR_LOCK_DIS_BIT])
    begin
      // re-enabling needs a fresh lock reset before the lock counter runs again
      next_st.lock_rdy  = 1'b0;
      next_st.lock_cnt  = '0;
      next_st.lock_hold = 1'b1;
    end
    // read latency pipe: first data at registration plus m clocks
    next_st.lat_half = half_of(st.mr[MR_CL_LSB +: 3]);
    next_st.rd_pipe[7:1] = st.rd_pipe[6:0];
    if (st.rd_pipe[st.lat_half[3:1] - 3'h1])
    begin
      next_st.first = 1'b1;
      next_st.emit  = 1'b1;
    end
    // burst column stepping, held when buffer back-pressures
    if (st.bst && buf_in_ready)
    begin
      next_st.col = order_col;
      if (st.beats_left == 3'h0)
        next_st.bst = 1'b0;
      else
      begin
        next_st.beat = 3'(st.beat + 3'h1);
        next_st.beats_left = 3'(st.beats_left - 3'h1);
        if (!st.bwr)
          next_st.emit = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st      <= '0;
      st.cs_q <= 1'b1;
      st.ras_q <= 1'b1;
      st.cas_q <= 1'b1;
      st.we_q  <= 1'b1;
      st.mr   <= MR_RESET;
      st.emr  <= EMR_RESET;
      st.cmd  <= DDRC_NOP;
      st.lat_half <= HALF_3;
    end
    else
      st <= next_st;
  end

  assign rd_valid  = st.dvalid;
  assign rd_data   = st.dout;
  assign rd_stall  = st.stall;
  assign cmd_code  = st.cmd;
  assign cmd_bank  = st.bank;
  assign auto_precharge  = st.ap;
  assign precharge_banks = st.pre_banks;
  assign burst_col       = st.col;
  assign burst_active    = st.bst;
  assign burst_is_write  = st.bwr;
  assign first_data      = st.first;
  assign read_latency_setting = st.mr[MR_CL_LSB +: 3];
  assign burst_len_code  = st.mr[MR_BL_LSB +: 2];
  assign burst_interleave = st.mr[MR_BT_BIT];
  assign lock_enabled    = ~st.emr[EMR_LOCK_DIS_BIT];
  assign lock_reset_pulse = st.lrst_p;
  assign lock_ready      = st.lock_rdy;
  assign drive_reduced   = st.emr[EMR_DRIVE_BIT];
  assign self_refresh    = st.self_ref;
  assign refresh_pulse   = st.ref_p;
endmodule : ddrc_top

//--- tb/ddrc_top_monitor.sv
// assertion checker for command decode, read timing and lock timing
module ddrc_top_monitor
  import ddrc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              cke,
  input wire logic              cs_b,
  input wire logic              ras_b,
  input wire logic              cas_b,
  input wire logic              we_b,
  input wire logic              bank_select_low,
  input wire logic              bank_select_high,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0]        cmd_code,
  input wire logic              auto_precharge,
  input wire logic [3:0]        precharge_banks,
  input wire logic [COL_W-1:0]  burst_col,
  input wire logic              burst_active,
  input wire logic              burst_interleave,
  input wire logic [1:0]        burst_len_code,
  input wire logic              first_data,
  input wire logic [2:0]        read_latency_setting,
  input wire logic              lock_enabled,
  input wire logic              lock_reset_pulse,
  input wire logic              lock_ready,
  input wire logic              self_refresh,
  input wire logic              rd_stall
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic       pin_rd;
  logic       pin_pre;
  logic [7:0] since_lr;
  assign pin_rd  = cke && !cs_b && ras_b && !cas_b && we_b;
  assign pin_pre = cke && !cs_b && !ras_b && cas_b && !we_b;

  // saturates so a long idle run cannot wrap back into the window
  always_ff @(posedge mclk)
  begin
    if (!rst_b || lock_reset_pulse)
      since_lr <= 8'h00;
    else if (since_lr != 8'hff)
      since_lr <= since_lr + 8'h01;
  end

  sequence rd_taken;
    cmd_code == DDRC_RD;
  endsequence
  sequence pre_taken;
    $past(pin_pre, 2) && $past(cke, 3);
  endsequence

  rd_decode_a: assert property ($past(pin_rd, 2) && $past(cke, 3) |->
    cmd_code == DDRC_RD) else $error("read pins not decoded");
  desel_a: assert property ($past(cs_b, 2) |->
    cmd_code inside {DDRC_DESEL, DDRC_NOP}) else $error("deselect decoded");
  lat_two_a: assert property (rd_taken ##0
    read_latency_setting == CL_CODE_2 |-> ##2 first_data)
    else $error("latency two missed");
  lat_half_a: assert property (rd_taken ##0
    read_latency_setting == CL_CODE_25 |-> ##2 first_data)
    else $error("latency two and a half missed");
  lat_three_a: assert property (rd_taken ##0
    read_latency_setting == CL_CODE_3 |-> ##3 first_data)
    else $error("latency three missed");
  auto_pre_a: assert property ($past(pin_rd && addr[AP_BIT], 2) &&
    $past(cke, 3) |-> auto_precharge) else $error("auto precharge lost");
  pre_all_a: assert property (pre_taken ##0 $past(addr[AP_BIT], 2)
    |-> precharge_banks == 4'hf) else $error("precharge all wrong");
  pre_one_a: assert property (pre_taken ##0 !$past(addr[AP_BIT], 2) |->
    precharge_banks == (4'h1 << $past({bank_select_high, bank_select_low}, 2)))
    else $error("single bank precharge wrong");
  lock_drop_a: assert property (lock_reset_pulse |=> !lock_ready [*8])
    else $error("lock ready too early");
  lock_wait_a: assert property ($rose(lock_ready) |->
    since_lr >= 8'hbe && since_lr <= 8'hd7) else $error("lock wait wrong");
  seq_step_a: assert property (burst_active && $past(burst_active) &&
    $past(burst_active, 2) && !rd_stall &&
    !(cmd_code inside {DDRC_RD, DDRC_WR}) && !burst_interleave &&
    burst_len_code == BL_CODE_8[1:0] |-> burst_col[2:0] ==
    $past(burst_col[2:0]) + 3'h1) else $error("sequential step wrong");
  sref_exit_a: assert property ($fell(self_refresh) |-> ##[0:2]
    lock_enabled) else $error("lock not enabled on exit");
endmodule : ddrc_top_monitor

bind ddrc_top ddrc_top_monitor mon (.*);

//--- tb/ddrc_ctrl_model.sv
// controller-side model driving command pins and the core data source
module ddrc_ctrl_model
  import ddrc_pkg::*;
(
  input  wire logic              mclk,
  output logic                   cke,
  output logic                   cs_b,
  output logic                   ras_b,
  output logic                   cas_b,
  output logic                   we_b,
  output logic                   bank_select_low,
  output logic                   bank_select_high,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] core_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = 4'h7;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = 13'h0000;
    core_rd_data = 16'h0000;
  end

  // fresh word every cycle so a stale capture shows up
  always @(posedge mclk)
    core_rd_data <= core_rd_data + 16'h1111;

  // one clock of pins, then nop with the released bus inverted
  task automatic issue(input logic [3:0] pins, input logic [1:0] bank,
                       input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    #1;
    {cs_b, ras_b, cas_b, we_b} = pins;
    {bank_select_high, bank_select_low} = bank;
    addr = a;
    @(posedge mclk);
    #1;
    {cs_b, ras_b, cas_b, we_b} = 4'h7;
    {bank_select_high, bank_select_low} = ~bank;
    addr = ~a;
  endtask : issue

  task automatic set_cke(input logic v);
    @(posedge mclk);
    #1;
    cke = v;
  endtask : set_cke
endmodule : ddrc_ctrl_model

//--- tb/ddrc_top_tb_top.sv
// self-checking bench for the registered command decode block
module ddrc_top_tb_top
  import ddrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk, rst_b, cke, cs_b, ras_b, cas_b, we_b, rd_ready;
  logic              bank_select_low, bank_select_high, rd_valid, rd_stall;
  logic              auto_precharge, burst_active, burst_is_write;
  logic              first_data, burst_interleave, lock_enabled;
  logic              lock_reset_pulse, lock_ready, drive_reduced;
  logic              self_refresh, refresh_pulse;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] core_rd_data, rd_data;
  logic [3:0]        cmd_code, precharge_banks;
  logic [BANK_W-1:0] cmd_bank;
  logic [COL_W-1:0]  burst_col;
  logic [2:0]        read_latency_setting;
  logic [1:0]        burst_len_code;
  int                bad_count, check_count;

  ddrc_ctrl_model m (.*);
  ddrc_top #(.COL_TOP(12)) dut (.*);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // bounded wait; running out ends the run
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      tick(1);
      n++;
    end
    check(s, v);
    if (s !== v)
      close_out();
  endtask : wait_lvl

  task automatic mrs(input logic [1:0] bank, input logic [ADDR_W-1:0] op);
    m.issue(4'h0, bank, op);
    tick(3);
  endtask : mrs

  task automatic mode_is(input logic [2:0] lat, input logic [2:0] bl,
                         input logic bt);
    check(read_latency_setting, lat);
    check(burst_len_code, bl[1:0]);
    check(burst_interleave, bt);
  endtask : mode_is

  initial
  begin
    logic [3:0]       pins [8];
    ddrc_cmd_e        want [8];
    logic [2:0]       lat [3];
    logic [COL_W-1:0] ex;
    int               bl, ld;
    pins = '{4'h7, 4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h2, 4'h1};
    want = '{DDRC_NOP, DDRC_DESEL, DDRC_ACT, DDRC_WR, DDRC_RD, DDRC_BST,
             DDRC_PRE, DDRC_AREF};
    lat = '{CL_CODE_2, CL_CODE_25, CL_CODE_3};
    bad_count = 0;
    check_count = 0;
    rst_b = 1'b0;
    rd_ready = 1'b1;
    tick(4);
    rst_b = 1'b1;
    mode_is(CL_CODE_2, BL_CODE_2, 1'b0);
    check(lock_enabled, 1'b1);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      m.issue(pins[i], 2'h0, 13'h0000);
      tick(1);
      check(cmd_code, want[i]);
      check(refresh_pulse, i == 7);
      check(burst_is_write, i == 3);
    end
    $display("decode done");
    foreach (lat[li])
      for (int b = 1; b <= 3; b++)
        for (int t = 0; t < 2; t++)
        begin
          bl = 1 << b;
          ld = (lat[li] == CL_CODE_3) ? 3 : 2;
          mrs(2'h0, {6'h00, lat[li], t[0], b[2:0]});
          mode_is(lat[li], b[2:0], t[0]);
          m.issue(4'h5, 2'h1, 13'h0035);
          tick(1);
          for (int k = 0; k < 9; k++)
          begin
            ex = COL_W'((32'h35 & ~(bl - 1)) |
                        ((t ? (32'h35 ^ (k - 1)) : (32'h35 + k - 1)) &
                         (bl - 1)));
            if (k >= 1 && k <= bl)
              check(burst_col, ex);
            check(burst_active, k < bl);
            check(first_data, k == ld);
            tick(1);
          end
        end
    $display("burst order and latency done");
    mrs(2'h3, 13'h0022);
    mrs(2'h0, 13'h0222);
    mode_is(CL_CODE_3, BL_CODE_8, 1'b1);
    mrs(2'h1, 13'h0003);
    check(lock_enabled, 1'b0);
    check(drive_reduced, 1'b1);
    m.set_cke(1'b0);
    tick(3);
    m.issue(4'h1, 2'h0, 13'h0000);
    wait_lvl(self_refresh, 1'b1, 10);
    m.set_cke(1'b1);
    wait_lvl(self_refresh, 1'b0, 10);
    tick(2);
    check(lock_enabled, 1'b1);
    check(drive_reduced, 1'b1);
    $display("extended register and self refresh done");
    mrs(2'h1, 13'h0002);
    m.issue(4'h0, 2'h0, 13'h0133);
    wait_lvl(lock_reset_pulse, 1'b1, 5);
    check(lock_ready, 1'b0);
    tick(150);
    check(lock_ready, 1'b0);
    mode_is(CL_CODE_3, BL_CODE_8, 1'b0);
    wait_lvl(lock_ready, 1'b1, 80);
    mrs(2'h0, 13'h0033);
    $display("lock reset done");
    m.issue(4'h2, 2'h2, 13'h0000);
    tick(1);
    check(precharge_banks, 4'h4);
    m.issue(4'h2, 2'h1, 13'h0400);
    tick(1);
    check(precharge_banks, 4'hf);
    rd_ready = 1'b0;
    m.issue(4'h5, 2'h3, 13'h0400);
    tick(1);
    check(auto_precharge, 1'b1);
    check(cmd_bank, 2'h3);
    wait_lvl(rd_stall, 1'b1, 20);
    check(rd_valid, 1'b1);
    rd_ready = 1'b1;
    wait_lvl(rd_valid, 1'b0, 20);
    m.issue(4'h5, 2'h0, 13'h0000);
    m.issue(4'h6, 2'h0, 13'h0000);
    wait_lvl(burst_active, 1'b0, 3);
    $display("precharge, buffer and terminate done");
    close_out();
  end
endmodule : ddrc_top_tb_top
